// >>> design/pps_hazard_unit.sv
// Purpose: decides whether the instruction in decode must wait
// Assumes: the instruction in decode reads two source registers
// Notes: purely combinational
`timescale 1ns/10ps
`default_nettype none
module pps_hazard_unit #(
    parameter int REG_ADDR_W = 4
) (
    pps_hazard_if.chk hz
);
    logic [1:0] srcHit;
    logic exWritesLate;
    logic decUsesMul;

    // the two operand ports are checked alike
    for (genvar i = 0; i < 2; i++) begin : gSrc
        assign srcHit[i] = (i == 0) ? (hz.decSrcA == hz.exDst) : (hz.decSrcB == hz.exDst);
    end

    always_comb begin
        // loaded or dsp-moved values reach the register only after the memory slot
        exWritesLate = hz.exValid && (hz.exClass == pps_pkg::CLS_LOAD ||
                                      hz.exClass == pps_pkg::CLS_DSP_TO_REG);
        decUsesMul = hz.decClass == pps_pkg::CLS_MUL_ACC_TO_REG ||
                     hz.decClass == pps_pkg::CLS_MUL_ACC_TO_MEM;
        hz.mulStall = hz.decValid && decUsesMul && hz.mulBusy;
        hz.useStall = hz.decValid && exWritesLate && (|srcHit);
        // a blocked memory slot also freezes operate, so decode cannot move on
        hz.stall = hz.mulStall || hz.useStall || (hz.decValid && hz.maBlock);
    end
endmodule
`default_nettype wire

// >>> design/pps_stage_seq.sv
// Purpose: pipeline sequencing of decode, operate, memory and write-back slots
// Assumes: fetch delivers one instruction per slot through issueValid/issueReady
// Notes: long instructions hold decode for their cycle count, extra stages sit in memory slots
// Behaviour
// - mul_acc_high/low to register: five stages, one cycle, waits on busy multiplier
// - dsp register to register: interlocks next user of destination, memory slot holds fetch
// - mul_acc half to memory predecrement: four stages, one cycle, multiplier wait, fetch clash
// - dsp register to memory predecrement: four stages, one cycle, no contention
// - software_trap: nine stages, eight execution cycles
// - cycle counts are minimums; contention with followers adds cycles
// - register transfers finish in fetch, decode_stage and operate_stage
// - register transfers move data through the ALU in operate_stage
// - loads pass fetch, decode, operate, memory access and write-back stages
// - follower using a load destination stalls until the loaded value exists
// - stores use four stages with no write-back stage
`timescale 1ns/10ps
`default_nettype none
`include "pps_defines.svh"
module pps_stage_seq #(
    parameter int REG_ADDR_W = 4
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic issueValid,
    input wire pps_pkg::pps_class_t issueClass,
    input wire logic [REG_ADDR_W-1:0] issueDst,
    input wire logic [REG_ADDR_W-1:0] issueSrcA,
    input wire logic [REG_ADDR_W-1:0] issueSrcB,
    output logic issueReady,
    input wire logic mulBusy,
    input wire logic wakePin,
    output logic exValid,
    output logic aluMove,
    output logic maValid,
    output logic fetchHold,
    output logic wbValid,
    output logic [REG_ADDR_W-1:0] wbReg,
    output logic lowPower
);
    if (REG_ADDR_W < 1 || REG_ADDR_W > 8) begin : gBadWidth
        $error("pps_stage_seq: REG_ADDR_W must be 1 to 8");
    end

    typedef logic [`PPS_CNT_W-1:0] pps_cnt_t;

    function automatic pps_cnt_t stagesOf(input pps_pkg::pps_class_t c);
        unique case (c)
            pps_pkg::CLS_REG_MOVE: stagesOf = `PPS_STG_REG_MOVE;
            pps_pkg::CLS_LOAD: stagesOf = `PPS_STG_LOAD;
            pps_pkg::CLS_STORE: stagesOf = `PPS_STG_STORE;
            pps_pkg::CLS_MUL_ACC_TO_REG: stagesOf = `PPS_STG_MAC_TO_REG;
            pps_pkg::CLS_DSP_TO_REG: stagesOf = `PPS_STG_DSP_TO_REG;
            pps_pkg::CLS_MUL_ACC_TO_MEM: stagesOf = `PPS_STG_MAC_TO_MEM;
            pps_pkg::CLS_DSP_TO_MEM: stagesOf = `PPS_STG_DSP_TO_MEM;
            pps_pkg::CLS_EXCEPTION_RETURN: stagesOf = `PPS_STG_EXC_RETURN;
            pps_pkg::CLS_SOFTWARE_TRAP: stagesOf = `PPS_STG_SW_TRAP;
            pps_pkg::CLS_SLEEP: stagesOf = `PPS_STG_SLEEP;
            default: stagesOf = `PPS_STG_REG_MOVE;
        endcase
    endfunction

    function automatic pps_cnt_t cyclesOf(input pps_pkg::pps_class_t c);
        unique case (c)
            pps_pkg::CLS_EXCEPTION_RETURN: cyclesOf = `PPS_CYC_EXC_RETURN;
            pps_pkg::CLS_SOFTWARE_TRAP: cyclesOf = `PPS_CYC_SW_TRAP;
            pps_pkg::CLS_SLEEP: cyclesOf = `PPS_CYC_SLEEP;
            default: cyclesOf = `PPS_CYC_LOAD;
        endcase
    endfunction

    function automatic logic writesBack(input pps_pkg::pps_class_t c);
        writesBack = c == pps_pkg::CLS_LOAD || c == pps_pkg::CLS_MUL_ACC_TO_REG || c == pps_pkg::CLS_DSP_TO_REG;
    endfunction

    // memory slots after operate: everything beyond the front three, less the write-back slot
    function automatic pps_cnt_t maSlotsOf(input pps_pkg::pps_class_t c);
        maSlotsOf = stagesOf(c) - `PPS_STG_FRONT - pps_cnt_t'(writesBack(c));
    endfunction

    // every memory slot but the dsp store shares the bus with fetch
    function automatic logic contendsFetch(input pps_pkg::pps_class_t c);
        contendsFetch = c != pps_pkg::CLS_DSP_TO_MEM;
    endfunction

    pps_hazard_if #(.REG_ADDR_W(REG_ADDR_W)) hz ();
    pps_hazard_unit #(.REG_ADDR_W(REG_ADDR_W)) uHazard (.hz(hz.chk));

    pps_pkg::pps_core_state_t coreState_r, coreState_nxt;
    logic idValid_r, idValid_nxt;
    pps_pkg::pps_class_t idClass_r, idClass_nxt;
    logic [REG_ADDR_W-1:0] idDst_r, idDst_nxt, idSrcA_r, idSrcA_nxt, idSrcB_r, idSrcB_nxt;
    pps_cnt_t idCnt_r, idCnt_nxt;
    logic exValid_r, exValid_nxt, exAlu_r, exAlu_nxt;
    pps_pkg::pps_class_t exClass_r, exClass_nxt;
    logic [REG_ADDR_W-1:0] exDst_r, exDst_nxt;
    logic maValid_r, maValid_nxt;
    pps_pkg::pps_class_t maClass_r, maClass_nxt;
    logic [REG_ADDR_W-1:0] maDst_r, maDst_nxt;
    pps_cnt_t maCnt_r, maCnt_nxt;
    logic wbValid_r, wbValid_nxt;
    logic [REG_ADDR_W-1:0] wbReg_r, wbReg_nxt;
    logic wakeMeta_r, wakeSync_r;
    logic maBlock, exMove, idDone, accept;

    assign hz.decValid = idValid_r;
    assign hz.decClass = idClass_r;
    assign hz.decSrcA = idSrcA_r;
    assign hz.decSrcB = idSrcB_r;
    assign hz.exValid = exValid_r;
    assign hz.exClass = exClass_r;
    assign hz.exDst = exDst_r;
    assign hz.mulBusy = mulBusy;
    assign hz.maBlock = maBlock;

    always_comb begin
        // an instruction still owed more memory slots keeps operate where it is
        maBlock = maValid_r && maCnt_r > pps_cnt_t'(1);
        exMove = !maBlock;
        // decode leaves only after its full execution-cycle count, stalls stretch it
        idDone = idValid_r && !hz.stall && idCnt_r == pps_cnt_t'(1);
        issueReady = coreState_r == pps_pkg::CORE_RUN && (!idValid_r || idDone) &&
                     !(exValid_r && exClass_r == pps_pkg::CLS_SLEEP) &&
                     !(idValid_r && idClass_r == pps_pkg::CLS_SLEEP);
        accept = issueValid && issueReady;
        fetchHold = maValid_r && contendsFetch(maClass_r);
    end

    always_comb begin
        coreState_nxt = coreState_r;
        idValid_nxt = idValid_r;
        idClass_nxt = idClass_r;
        idDst_nxt = idDst_r;
        idSrcA_nxt = idSrcA_r;
        idSrcB_nxt = idSrcB_r;
        idCnt_nxt = idCnt_r;
        if (accept) begin
            idValid_nxt = 1'b1;
            idClass_nxt = issueClass;
            idDst_nxt = issueDst;
            idSrcA_nxt = issueSrcA;
            idSrcB_nxt = issueSrcB;
            idCnt_nxt = cyclesOf(issueClass);
        end else if (idDone) begin
            idValid_nxt = 1'b0;
        end else if (idValid_r && !hz.stall) begin
            idCnt_nxt = idCnt_r - pps_cnt_t'(1);
        end
        unique case (coreState_r)
            pps_pkg::CORE_RUN: begin
                if (exValid_r && exClass_r == pps_pkg::CLS_SLEEP) begin
                    coreState_nxt = pps_pkg::CORE_SLEEP;
                end
            end
            pps_pkg::CORE_SLEEP: begin
                if (wakeSync_r) begin
                    coreState_nxt = pps_pkg::CORE_RUN;
                end
            end
            default: coreState_nxt = pps_pkg::CORE_RUN;
        endcase
    end

    always_comb begin
        exValid_nxt = exValid_r;
        exClass_nxt = exClass_r;
        exDst_nxt = exDst_r;
        exAlu_nxt = exAlu_r;
        if (exMove) begin
            // a held decode leaves a bubble behind the work that moves on
            exValid_nxt = idDone;
            exClass_nxt = idClass_r;
            exDst_nxt = idDst_r;
            exAlu_nxt = idDone && idClass_r == pps_pkg::CLS_REG_MOVE;
        end
    end

    always_comb begin
        maValid_nxt = maValid_r;
        maClass_nxt = maClass_r;
        maDst_nxt = maDst_r;
        maCnt_nxt = maCnt_r;
        wbValid_nxt = 1'b0;
        wbReg_nxt = wbReg_r;
        if (maBlock) begin
            maCnt_nxt = maCnt_r - pps_cnt_t'(1);
        end else begin
            // register transfers and sleep end in operate; the rest take memory slots
            maValid_nxt = exValid_r && maSlotsOf(exClass_r) != pps_cnt_t'(0);
            maClass_nxt = exClass_r;
            maDst_nxt = exDst_r;
            maCnt_nxt = maSlotsOf(exClass_r);
            if (maValid_r && writesBack(maClass_r)) begin
                wbValid_nxt = 1'b1;
                wbReg_nxt = maDst_r;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            coreState_r <= pps_pkg::CORE_RUN;
            idValid_r <= 1'b0;
            idClass_r <= pps_pkg::CLS_REG_MOVE;
            idDst_r <= '0;
            idSrcA_r <= '0;
            idSrcB_r <= '0;
            idCnt_r <= '0;
            exValid_r <= 1'b0;
            exClass_r <= pps_pkg::CLS_REG_MOVE;
            exDst_r <= '0;
            exAlu_r <= 1'b0;
            maValid_r <= 1'b0;
            maClass_r <= pps_pkg::CLS_REG_MOVE;
            maDst_r <= '0;
            maCnt_r <= '0;
            wbValid_r <= 1'b0;
            wbReg_r <= '0;
            wakeMeta_r <= 1'b0;
            wakeSync_r <= 1'b0;
        end else begin
            coreState_r <= coreState_nxt;
            idValid_r <= idValid_nxt;
            idClass_r <= idClass_nxt;
            idDst_r <= idDst_nxt;
            idSrcA_r <= idSrcA_nxt;
            idSrcB_r <= idSrcB_nxt;
            idCnt_r <= idCnt_nxt;
            exValid_r <= exValid_nxt;
            exClass_r <= exClass_nxt;
            exDst_r <= exDst_nxt;
            exAlu_r <= exAlu_nxt;
            maValid_r <= maValid_nxt;
            maClass_r <= maClass_nxt;
            maDst_r <= maDst_nxt;
            maCnt_r <= maCnt_nxt;
            wbValid_r <= wbValid_nxt;
            wbReg_r <= wbReg_nxt;
            wakeMeta_r <= wakePin;
            wakeSync_r <= wakeMeta_r;
        end
    end

    assign exValid = exValid_r;
    assign aluMove = exAlu_r;
    assign maValid = maValid_r;
    assign wbValid = wbValid_r;
    assign wbReg = wbReg_r;
    assign lowPower = coreState_r == pps_pkg::CORE_SLEEP;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    alu_move_a: assert property (idDone && idClass_r == pps_pkg::CLS_REG_MOVE && exMove |=> aluMove)
        else $error("register transfer did not reach the ALU");
    mul_stall_a: assert property (idValid_r && mulBusy && exMove && (idClass_r == pps_pkg::CLS_MUL_ACC_TO_REG ||
        idClass_r == pps_pkg::CLS_MUL_ACC_TO_MEM) |=> !exValid_r)
        else $error("multiplier transfer left decode while multiplier busy");
    // the producer must move on into its memory slot while the follower leaves a bubble
    load_use_a: assert property (hz.useStall && exMove |=> !exValid_r && maValid_r && maDst_r == $past(exDst_r))
        else $error("load follower left decode too early");
    trap_hold_a: assert property (idDone && idClass_r == pps_pkg::CLS_SOFTWARE_TRAP |->
        $past(idValid_r, 7) && $past(idClass_r, 7) == pps_pkg::CLS_SOFTWARE_TRAP)
        else $error("software trap left decode before eight cycles");
    rte_hold_a: assert property (idDone && idClass_r == pps_pkg::CLS_EXCEPTION_RETURN |->
        $past(idValid_r, 3) && $past(idClass_r, 3) == pps_pkg::CLS_EXCEPTION_RETURN)
        else $error("exception return left decode before four cycles");
    sleep_enter_a: assert property (exValid_r && exClass_r == pps_pkg::CLS_SLEEP |=> lowPower && !issueReady)
        else $error("sleep did not enter low power");
    store_no_wb_a: assert property (maValid_r && maClass_r == pps_pkg::CLS_STORE && !maBlock |=> !wbValid)
        else $error("store produced a write-back");
    load_wb_a: assert property (maValid_r && maClass_r == pps_pkg::CLS_LOAD && !maBlock |=> wbValid && wbReg == $past(maDst_r))
        else $error("load missed its write-back slot");
    dsp_store_a: assert property (maValid_r && maClass_r == pps_pkg::CLS_DSP_TO_MEM |-> !fetchHold)
        else $error("dsp store held fetch");
    bubble_a: assert property (hz.stall && exMove |=> !exValid && !aluMove)
        else $error("stall did not insert a bubble");
endmodule
`default_nettype wire

// >>> shared/pps_defines.svh
// Purpose: timing figures of the pipeline stage sequencer
// Assumes: stage counts include the fetch stage
// Notes: cycle counts are the normal minimum without contention
`ifndef PPS_DEFINES_SVH
`define PPS_DEFINES_SVH
`define PPS_CNT_W 4
`define PPS_STG_REG_MOVE 4'h3
`define PPS_CYC_REG_MOVE 4'h1
`define PPS_STG_LOAD 4'h5
`define PPS_CYC_LOAD 4'h1
`define PPS_STG_STORE 4'h4
`define PPS_CYC_STORE 4'h1
`define PPS_STG_MAC_TO_REG 4'h5
`define PPS_CYC_MAC_TO_REG 4'h1
`define PPS_STG_DSP_TO_REG 4'h5
`define PPS_CYC_DSP_TO_REG 4'h1
`define PPS_STG_MAC_TO_MEM 4'h4
`define PPS_CYC_MAC_TO_MEM 4'h1
`define PPS_STG_DSP_TO_MEM 4'h4
`define PPS_CYC_DSP_TO_MEM 4'h1
`define PPS_STG_EXC_RETURN 4'h5
`define PPS_CYC_EXC_RETURN 4'h4
`define PPS_STG_SW_TRAP 4'h9
`define PPS_CYC_SW_TRAP 4'h8
`define PPS_STG_SLEEP 4'h3
`define PPS_CYC_SLEEP 4'h3
// fetch, decode and operate stages come before any memory or write-back slot
`define PPS_STG_FRONT 4'h3
`endif

// >>> shared/pps_hazard_if.sv
// Purpose: carries decode and operate stage facts to the hazard check
// Assumes: one clock, decode and operate fields from flip-flops of the sequencer, mulBusy straight from its input port
// Notes: the check answers in the same cycle
`timescale 1ns/10ps
`default_nettype none
interface pps_hazard_if #(parameter int REG_ADDR_W = 4);
    logic decValid;
    pps_pkg::pps_class_t decClass;
    logic [REG_ADDR_W-1:0] decSrcA;
    logic [REG_ADDR_W-1:0] decSrcB;
    logic exValid;
    pps_pkg::pps_class_t exClass;
    logic [REG_ADDR_W-1:0] exDst;
    logic mulBusy;
    logic maBlock;
    logic mulStall;
    logic useStall;
    logic stall;
    modport seq (output decValid, decClass, decSrcA, decSrcB, exValid, exClass, exDst, mulBusy, maBlock,
                 input mulStall, useStall, stall);
    modport chk (input decValid, decClass, decSrcA, decSrcB, exValid, exClass, exDst, mulBusy, maBlock,
                 output mulStall, useStall, stall);
endinterface
`default_nettype wire

// >>> shared/pps_pkg.sv
// Purpose: types of the pipeline stage sequencer
// Assumes: nothing
// Notes: instruction classes group instructions of equal pipeline shape
package pps_pkg;
    typedef enum logic [3:0] {
        CLS_REG_MOVE = 4'h0,
        CLS_LOAD = 4'h1,
        CLS_STORE = 4'h2,
        CLS_MUL_ACC_TO_REG = 4'h3,
        CLS_DSP_TO_REG = 4'h4,
        CLS_MUL_ACC_TO_MEM = 4'h5,
        CLS_DSP_TO_MEM = 4'h6,
        CLS_EXCEPTION_RETURN = 4'h7,
        CLS_SOFTWARE_TRAP = 4'h8,
        CLS_SLEEP = 4'h9
    } pps_class_t;
    typedef enum logic [1:0] {
        CORE_RUN = 2'b01,
        CORE_SLEEP = 2'b10
    } pps_core_state_t;
endpackage

// >>> verif/pps_fetch_model.sv
// Purpose: fetch side model offering queued instructions to decode
// Assumes: an offer stands unchanged until decode takes it
// Notes: idle issueDst, issueSrcA and issueSrcB toggle so a stale value never looks like a live offer
`timescale 1ns/10ps
`default_nettype none
module pps_fetch_model (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic issueReady,
    output logic issueValid,
    output pps_pkg::pps_class_t issueClass,
    output logic [3:0] issueDst,
    output logic [3:0] issueSrcA,
    output logic [3:0] issueSrcB
);
    logic [15:0] progQ[$];
    initial begin
        issueValid = 1'b0;
        issueClass = pps_pkg::CLS_REG_MOVE;
        issueDst = 4'h0;
        issueSrcA = 4'h0;
        issueSrcB = 4'h0;
    end
    task automatic push(input logic [15:0] w);
        progQ.push_back(w);
    endtask
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            issueValid <= 1'b0;
        end else begin
            if (issueValid && issueReady && progQ.size() > 0) begin
                void'(progQ.pop_front());
            end
            if (progQ.size() > 0) begin
                issueValid <= 1'b1;
                issueClass <= pps_pkg::pps_class_t'(progQ[0][15:12]);
                issueDst <= progQ[0][11:8];
                issueSrcA <= progQ[0][7:4];
                issueSrcB <= progQ[0][3:0];
            end else begin
                issueValid <= 1'b0;
                issueDst <= ~issueDst;
                issueSrcA <= ~issueSrcA;
                issueSrcB <= ~issueSrcB;
            end
        end
    end
endmodule
`default_nettype wire

// >>> verif/tb.sv
// Purpose: self-checking bench of the pipeline stage sequencer
// Assumes: reference tables below hold the stage and cycle figures per class
// Notes: latency is measured from the take edge, so fetch-side slack does not matter
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic mulBusy = 1'b0;
    logic wakePin = 1'b0;
    logic issueValid, issueReady, exValid, aluMove, maValid, fetchHold, wbValid, lowPower;
    pps_pkg::pps_class_t issueClass;
    logic [3:0] issueDst, issueSrcA, issueSrcB, wbReg, lastWb;
    logic [31:0] lfsrState = 32'hd611;
    int n_fail = 0;
    int comparisons = 0;
    int cyc = 0;
    int nMa, nWb, nAlu, nHold;
    int takeQ[$];
    int exQ[$];
    always #12.5 sys_clk = ~sys_clk;
    pps_stage_seq dut (.sys_clk(sys_clk), .reset_n(reset_n), .issueValid(issueValid), .issueClass(issueClass),
        .issueDst(issueDst), .issueSrcA(issueSrcA), .issueSrcB(issueSrcB), .issueReady(issueReady),
        .mulBusy(mulBusy), .wakePin(wakePin), .exValid(exValid), .aluMove(aluMove), .maValid(maValid),
        .fetchHold(fetchHold), .wbValid(wbValid), .wbReg(wbReg), .lowPower(lowPower));
    pps_fetch_model fetch (.sys_clk(sys_clk), .reset_n(reset_n), .issueReady(issueReady),
        .issueValid(issueValid), .issueClass(issueClass), .issueDst(issueDst), .issueSrcA(issueSrcA),
        .issueSrcB(issueSrcB));
    always @(posedge sys_clk) begin
        cyc++;
        if (reset_n) begin
            if (issueValid === 1'b1 && issueReady === 1'b1) takeQ.push_back(cyc);
            if (exValid === 1'b1) exQ.push_back(cyc);
            if (maValid === 1'b1) nMa++;
            if (wbValid === 1'b1) nWb++;
            if (aluMove === 1'b1) nAlu++;
            if (fetchHold === 1'b1) nHold++;
            if (wbValid === 1'b1) lastWb = wbReg;
        end
    end
    // reference figures per class code
    function automatic int expCycles(input int c);
        case (c)
            7: return 4;
            8: return 8;
            9: return 3;
            default: return 1;
        endcase
    endfunction
    function automatic int expStages(input int c);
        case (c)
            0, 9: return 3;
            2, 5, 6: return 4;
            8: return 9;
            default: return 5;
        endcase
    endfunction
    function automatic int expWb(input int c);
        return (c == 1 || c == 3 || c == 4) ? 1 : 0;
    endfunction
    function automatic logic [31:0] nextRand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic clear_mon();
        takeQ.delete();
        exQ.delete();
        nMa = 0;
        nWb = 0;
        nAlu = 0;
        nHold = 0;
        lastWb = 4'h0;
    endtask
    task automatic wait_takes(input int n);
        int k;
        k = 0;
        while (takeQ.size() < n && k < 200) begin
            @(posedge sys_clk);
            #1;
            k++;
        end
        if (takeQ.size() < n) begin
            n_fail++;
            $display("BAD %0t instruction never taken", $time);
            tally_and_finish();
        end
    endtask
    task automatic run_one(input int c);
        logic [3:0] d;
        int em;
        lfsrState = nextRand(lfsrState);
        d = lfsrState[3:0];
        em = expStages(c) - 3 - expWb(c);
        clear_mon();
        fetch.push({c[3:0], d, d ^ 4'h1, d ^ 4'h2});
        wait_takes(1);
        repeat (20) @(posedge sys_clk);
        #1;
        check(exQ.size(), 1, "operate count");
        check(exQ[0] - takeQ[0], expCycles(c) + 1, "operate delay");
        check(nMa, em, "memory slots");
        check(nWb, expWb(c), "write-back count");
        check(nHold, (c == 6) ? 0 : em, "fetch hold");
        check(nAlu, (c == 0) ? 1 : 0, "alu move");
        if (expWb(c) == 1) check(lastWb, d, "write-back reg");
        if (c == 9) begin
            check(lowPower, 1'b1, "asleep");
            fetch.push({4'h0, d, d, d});
            repeat (5) @(posedge sys_clk);
            #1;
            check(takeQ.size(), 1, "taken while asleep");
            @(posedge sys_clk);
            wakePin <= 1'b1;
            wait_takes(2);
            @(posedge sys_clk);
            wakePin <= 1'b0;
            #1;
            check(lowPower, 1'b0, "awake");
            // let the wake-up instruction drain so the next scenario starts empty
            repeat (5) @(posedge sys_clk);
            #1;
        end
    endtask
    task automatic pair(input int ca, input int cb, input bit dep, input int gap);
        logic [3:0] d;
        lfsrState = nextRand(lfsrState);
        d = lfsrState[3:0];
        clear_mon();
        fetch.push({ca[3:0], d, d ^ 4'h3, d ^ 4'h5});
        fetch.push({cb[3:0], d ^ 4'h6, dep ? d : d ^ 4'h7, d ^ 4'h9});
        wait_takes(2);
        repeat (20) @(posedge sys_clk);
        #1;
        check(exQ.size(), 2, "pair operate count");
        check(exQ[1] - exQ[0], gap, "pair spacing");
        if (ca == 1) check(lastWb, d, "load write-back");
    endtask
    task automatic mul_case(input int c);
        clear_mon();
        @(posedge sys_clk);
        mulBusy <= 1'b1;
        fetch.push({c[3:0], 4'h2, 4'h3, 4'h4});
        wait_takes(1);
        repeat (5) @(posedge sys_clk);
        mulBusy <= 1'b0;
        repeat (15) @(posedge sys_clk);
        #1;
        check(exQ.size(), 1, "stalled operate count");
        // busy for five decode cycles after the take, then the single execution cycle
        check(exQ[0] - takeQ[0], (c == 6) ? 2 : 7, "multiplier stall");
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        for (int c = 0; c < 10; c++) run_one(c);
        // follower dependent on a load or dsp move must lose exactly one slot, independent or after a register transfer none
        pair(1, 0, 1'b1, 2);
        pair(1, 0, 1'b0, 1);
        pair(4, 0, 1'b1, 2);
        pair(0, 0, 1'b1, 1);
        mul_case(3);
        mul_case(5);
        mul_case(6);
        tally_and_finish();
    end
endmodule
`default_nettype wire
